// ---- design/mpio_top.sv ----
// Pin I/O logic for the interrupt, shared, parallel and control ports.
// Assumes an Avalon-MM master on clk, pins resolved by the bench from oe.
//
// Our own choice: the Avalon-MM register port.
`default_nettype none
module mpio_top (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Avalon-MM slave
	input wire logic [mpio_pkg::MPIO_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [mpio_pkg::MPIO_DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [mpio_pkg::MPIO_DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	// Interrupt-capable port pins
	input wire logic [7:0] irq_port_in,
	output mpio_pkg::mpio_pin8_t irq_port_drive,
	output logic [7:0] irq_port_pullup,
	// Shared port pins and peripherals
	input wire logic [7:0] shared_port_in,
	output mpio_pkg::mpio_pin8_t shared_port_drive,
	input wire mpio_pkg::mpio_periph_t shared_periph,
	output mpio_pkg::mpio_serial_in_t shared_periph_in,
	input wire logic i2c_enable,
	input wire logic serial_cke,
	output logic shared_smbus_levels,
	// Parallel port pins
	input wire logic [7:0] parallel_port_in,
	output mpio_pkg::mpio_pin8_t parallel_port_drive,
	output logic [7:0] parallel_port_pins,
	output logic parallel_slave_select,
	output logic port_ttl_buffers,
	// Control port pins and slave-port status
	input wire logic [2:0] control_port_in,
	output mpio_pkg::mpio_pin3_t control_port_drive,
	input wire logic [2:0] control_analog,
	output mpio_pkg::mpio_psp_ctl_t psp_ctl,
	input wire logic input_buffer_full,
	input wire logic output_buffer_full,
	// Special functions
	output logic [7:0] option_value,
	output logic external_irq_pin,
	output logic external_irq_rising,
	output logic change_irq_flag,
	input wire logic change_flag_clear,
	output logic low_voltage_programming,
	output logic lowvolt_prog_pin,
	output logic prog_clock_pin,
	output logic prog_data_pin
);
	import mpio_pkg::*;

	function automatic logic reg_hit(input logic [MPIO_ADDR_W-1:0] addr, input logic [7:0] idx);
		reg_hit = (addr[MPIO_ADDR_W-1:2] == idx) && (addr[1:0] == MPIO_WORD_LSB);
	endfunction

	function automatic logic [7:0] mux_drive(input logic [7:0] sel, input logic [7:0] a, input logic [7:0] b);
		mux_drive = (sel & a) | (~sel & b);
	endfunction

	// ============================================================
	// Input synchronisers
	localparam int SYNC_W = 27;
	logic [SYNC_W-1:0] sync_meta;
	logic [SYNC_W-1:0] sync_pins;
	wire [SYNC_W-1:0] raw_pins = {control_port_in, parallel_port_in, shared_port_in, irq_port_in};
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sync_meta <= '0;
			sync_pins <= '0;
		end else begin
			sync_meta <= raw_pins;
			sync_pins <= sync_meta;
		end
	end
	wire [7:0] irq_pins = sync_pins[7:0];
	wire [7:0] shared_pins = sync_pins[15:8];
	wire [7:0] par_pins = sync_pins[23:16];
	wire [2:0] ctl_pins = sync_pins[26:24];

	// ============================================================
	// Bus handshake: one wait cycle per access
	logic ack;
	wire req = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack;
	wire wr_fire = avs_write & ack & avs_byteenable[0];
	wire rd_fire = avs_read & ack;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			ack <= 1'b0;
		else
			ack <= req & ~ack;
	end
	wire [7:0] wdat = avs_writedata[7:0];
	wire hit_irq_data = reg_hit(avs_address, MPIO_IDX_IRQ_DATA);
	wire hit_sh_data = reg_hit(avs_address, MPIO_IDX_SHARED_DATA);
	wire hit_par_data = reg_hit(avs_address, MPIO_IDX_PAR_DATA);
	wire hit_ctl_data = reg_hit(avs_address, MPIO_IDX_CTL_DATA);
	wire hit_option = reg_hit(avs_address, MPIO_IDX_OPTION);
	wire hit_irq_dir = reg_hit(avs_address, MPIO_IDX_IRQ_DIR);
	wire hit_sh_dir = reg_hit(avs_address, MPIO_IDX_SHARED_DIR);
	wire hit_par_dir = reg_hit(avs_address, MPIO_IDX_PAR_DIR);
	wire hit_ctl_dir = reg_hit(avs_address, MPIO_IDX_CTL_DIR);
	wire hit_status = reg_hit(avs_address, MPIO_IDX_STATUS);

	// ============================================================
	// Configuration registers
	logic [7:0] option_reg;
	logic [7:0] irq_dir;
	logic [7:0] sh_dir;
	logic [7:0] par_dir;
	logic [2:0] ctl_dir;
	logic psp_mode;
	logic input_overflow;
	logic lvp_en;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			option_reg <= MPIO_OPTION_RST;
			irq_dir <= MPIO_DIR_RST;
			sh_dir <= MPIO_DIR_RST;
			par_dir <= MPIO_DIR_RST;
			ctl_dir <= MPIO_CTL_DIR_RST;
			psp_mode <= 1'b0;
			input_overflow <= 1'b0;
			lvp_en <= MPIO_LVP_RST;
		end else if (wr_fire) begin
			if (hit_option)
				option_reg <= wdat;
			if (hit_irq_dir)
				irq_dir <= wdat;
			if (hit_sh_dir)
				sh_dir <= wdat;
			if (hit_par_dir)
				par_dir <= wdat;
			if (hit_ctl_dir) begin
				ctl_dir <= wdat[2:0];
				psp_mode <= wdat[MPIO_CTL_PSP_MODE];
				input_overflow <= wdat[MPIO_CTL_INPUT_OVERFLOW];
			end
			if (hit_status)
				lvp_en <= wdat[MPIO_STAT_LVP];
		end
	end

	// ============================================================
	// Data latches, cleared only by the power-on reset
	logic [7:0] irq_latch;
	logic [7:0] sh_latch;
	logic [7:0] par_latch;
	logic [2:0] ctl_latch;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_latch <= MPIO_LATCH_RST;
			sh_latch <= MPIO_LATCH_RST;
			par_latch <= MPIO_LATCH_RST;
			ctl_latch <= MPIO_LATCH_RST[2:0];
		end else if (wr_fire) begin
			if (hit_irq_data)
				irq_latch <= wdat;
			if (hit_sh_data)
				sh_latch <= wdat;
			if (hit_par_data)
				par_latch <= wdat;
			if (hit_ctl_data)
				ctl_latch <= wdat[2:0];
		end
	end

	// ============================================================
	// Interrupt-capable port
	wire [7:0] lvp_mask = lvp_en ? (8'h01 << MPIO_PIN_LVP) : 8'h00;
	assign irq_port_drive.dout = irq_latch;
	assign irq_port_drive.oe = ~irq_dir & ~lvp_mask;
	assign irq_port_pullup = option_reg[MPIO_OPT_PULLUP_DIS] ? 8'h00 : irq_dir;
	wire [7:0] irq_read = irq_pins & ~lvp_mask;
	assign external_irq_pin = irq_pins[MPIO_PIN_EXT_IRQ];
	assign lowvolt_prog_pin = lvp_en & irq_pins[MPIO_PIN_LVP];
	assign low_voltage_programming = lvp_en;
	assign prog_clock_pin = irq_pins[MPIO_PIN_PGC];
	assign prog_data_pin = irq_pins[MPIO_PIN_PGD];
	assign option_value = option_reg;

	// External interrupt edge, polarity from the edge-select bit
	logic ext_prev;
	wire ext_now = irq_pins[MPIO_PIN_EXT_IRQ] ~^ option_reg[MPIO_OPT_INT_EDGE];
	assign external_irq_rising = ext_now & ~ext_prev;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			ext_prev <= 1'b1;
		else
			ext_prev <= ext_now;
	end

	// Change detection on the upper nibble
	logic [3:0] last_read;
	logic change_flag;
	wire port_touch = (rd_fire | wr_fire) & hit_irq_data;
	wire [3:0] mismatch = (irq_pins[7:4] ^ last_read) & irq_dir[7:4];
	wire change_set = |mismatch;
	wire change_clr = change_flag_clear | (wr_fire & hit_status & wdat[MPIO_STAT_CHANGE]);
	wire next_change_flag = change_set | (change_flag & ~change_clr);
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			last_read <= '0;
			change_flag <= 1'b0;
		end else begin
			if (port_touch)
				last_read <= irq_pins[7:4];
			change_flag <= next_change_flag;
		end
	end
	assign change_irq_flag = change_flag;

	// ============================================================
	// Shared port with peripheral override
	wire [7:0] sh_sel = shared_periph.sel;
	wire [7:0] sh_periph_oe = sh_sel & shared_periph.oe;
	assign shared_port_drive.oe = mux_drive(sh_sel, sh_periph_oe, ~sh_dir);
	assign shared_port_drive.dout = mux_drive(sh_sel, shared_periph.dout, sh_latch);
	wire [7:0] sh_dir_read = mux_drive(sh_sel, ~shared_periph.oe, sh_dir);
	assign shared_periph_in.t1_clk = shared_pins[MPIO_PIN_T1CK];
	assign shared_periph_in.t1_osc_in = shared_pins[MPIO_PIN_T1OSI];
	assign shared_periph_in.ccp2_in = shared_pins[MPIO_PIN_T1OSI];
	assign shared_periph_in.ccp1_in = shared_pins[MPIO_PIN_CCP1];
	assign shared_periph_in.sck_in = shared_pins[MPIO_PIN_SCK];
	assign shared_periph_in.sdi_in = shared_pins[MPIO_PIN_SDI];
	assign shared_periph_in.ck_in = shared_pins[MPIO_PIN_CK];
	assign shared_periph_in.rx_in = shared_pins[MPIO_PIN_RX];
	assign shared_smbus_levels = i2c_enable & serial_cke;

	// ============================================================
	// Parallel port and slave-port mode
	wire [7:0] par_gpio_oe = psp_mode ? 8'h00 : ~par_dir;
	assign parallel_port_drive.oe = par_gpio_oe;
	assign parallel_port_drive.dout = par_latch;
	assign parallel_port_pins = par_pins;
	assign parallel_slave_select = psp_mode;
	assign port_ttl_buffers = psp_mode;

	// ============================================================
	// Control port
	wire [2:0] ctl_digital = ~control_analog;
	assign control_port_drive.oe = ~ctl_dir;
	assign control_port_drive.dout = ctl_latch;
	wire [2:0] ctl_read = ctl_pins & ctl_digital;
	assign psp_ctl.rd_n = ~psp_mode | ctl_read[MPIO_PIN_RD];
	assign psp_ctl.wr_n = ~psp_mode | ctl_read[MPIO_PIN_WR];
	assign psp_ctl.cs_n = ~psp_mode | ctl_read[MPIO_PIN_CS];
	wire [7:0] ctl_dir_read = {input_buffer_full, output_buffer_full, input_overflow, psp_mode, 1'b0, ctl_dir};

	// ============================================================
	// Read data, captured on the wait cycle
	wire [7:0] status_read = {6'h00, lvp_en, change_flag};
	logic [7:0] rd_sel;
	always_comb begin
		rd_sel = 8'h00;
		unique case (1'b1)
			hit_irq_data: rd_sel = irq_read;
			hit_sh_data: rd_sel = shared_pins;
			hit_par_data: rd_sel = par_pins;
			hit_ctl_data: rd_sel = {5'h00, ctl_read};
			hit_option: rd_sel = option_reg;
			hit_irq_dir: rd_sel = irq_dir;
			hit_sh_dir: rd_sel = sh_dir_read;
			hit_par_dir: rd_sel = par_dir;
			hit_ctl_dir: rd_sel = ctl_dir_read;
			hit_status: rd_sel = status_read;
			default: rd_sel = 8'h00;
		endcase
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			avs_readdata <= '0;
		else if (avs_read & ~ack)
			avs_readdata <= {24'h000000, rd_sel};
	end
endmodule
`default_nettype wire

// ---- inc/mpio_pkg.sv ----
// Constants and carrier types for the multi-port pin I/O block.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
`default_nettype none
package mpio_pkg;
	// ============================================================
	// Bus and register indices (byte address = 4 * index)
	localparam int MPIO_ADDR_W = 10;
	localparam int MPIO_DATA_W = 32;
	localparam int MPIO_REG_W = 8;
	localparam logic [7:0] MPIO_IDX_IRQ_DATA = 8'h06;
	localparam logic [7:0] MPIO_IDX_SHARED_DATA = 8'h07;
	localparam logic [7:0] MPIO_IDX_PAR_DATA = 8'h08;
	localparam logic [7:0] MPIO_IDX_CTL_DATA = 8'h09;
	localparam logic [7:0] MPIO_IDX_OPTION = 8'h81;
	localparam logic [7:0] MPIO_IDX_IRQ_DIR = 8'h86;
	localparam logic [7:0] MPIO_IDX_SHARED_DIR = 8'h87;
	localparam logic [7:0] MPIO_IDX_PAR_DIR = 8'h88;
	localparam logic [7:0] MPIO_IDX_CTL_DIR = 8'h89;
	localparam logic [7:0] MPIO_IDX_STATUS = 8'h90;
	localparam logic [1:0] MPIO_WORD_LSB = 2'h0;
	// ============================================================
	// Reset values
	localparam logic [7:0] MPIO_DIR_RST = 8'hFF;
	localparam logic [7:0] MPIO_OPTION_RST = 8'hFF;
	localparam logic [7:0] MPIO_LATCH_RST = 8'h00;
	localparam logic [2:0] MPIO_CTL_DIR_RST = 3'h7;
	localparam logic MPIO_LVP_RST = 1'b1;
	// ============================================================
	// Field positions
	localparam int MPIO_OPT_PULLUP_DIS = 7;
	localparam int MPIO_OPT_INT_EDGE = 6;
	localparam int MPIO_CTL_IBF = 7;
	localparam int MPIO_CTL_OBF = 6;
	localparam int MPIO_CTL_INPUT_OVERFLOW = 5;
	localparam int MPIO_CTL_PSP_MODE = 4;
	localparam int MPIO_STAT_CHANGE = 0;
	localparam int MPIO_STAT_LVP = 1;
	localparam int MPIO_PIN_EXT_IRQ = 0;
	localparam int MPIO_PIN_LVP = 3;
	localparam int MPIO_PIN_PGC = 6;
	localparam int MPIO_PIN_PGD = 7;
	localparam int MPIO_PIN_T1CK = 0;
	localparam int MPIO_PIN_T1OSI = 1;
	localparam int MPIO_PIN_CCP1 = 2;
	localparam int MPIO_PIN_SCK = 3;
	localparam int MPIO_PIN_SDI = 4;
	localparam int MPIO_PIN_CK = 6;
	localparam int MPIO_PIN_RX = 7;
	localparam int MPIO_PIN_RD = 0;
	localparam int MPIO_PIN_WR = 1;
	localparam int MPIO_PIN_CS = 2;
	// ============================================================
	// Carrier types
	typedef struct packed {
		logic [7:0] sel;
		logic [7:0] oe;
		logic [7:0] dout;
	} mpio_periph_t;
	typedef struct packed {
		logic [7:0] dout;
		logic [7:0] oe;
	} mpio_pin8_t;
	typedef struct packed {
		logic [2:0] dout;
		logic [2:0] oe;
	} mpio_pin3_t;
	typedef struct packed {
		logic rd_n;
		logic wr_n;
		logic cs_n;
	} mpio_psp_ctl_t;
	typedef struct packed {
		logic t1_clk;
		logic t1_osc_in;
		logic ccp2_in;
		logic ccp1_in;
		logic sck_in;
		logic sdi_in;
		logic ck_in;
		logic rx_in;
	} mpio_serial_in_t;
endpackage
`default_nettype wire

// ---- tb/mpio_pins.sv ----
// Far-side pin model: resolves one 8-bit port from drive, pull-ups and outside level.
// Assumes the bench supplies the outside level and which pins it holds.
`default_nettype none
module mpio_pins (
	// Design side
	input wire logic clk,
	input wire mpio_pkg::mpio_pin8_t drive,
	input wire logic [7:0] pull_en,
	// Outside world
	input wire logic [7:0] ext,
	input wire logic [7:0] ext_en,
	output logic [7:0] pin
);
	timeunit 1ns;
	timeprecision 1ps;
	import mpio_pkg::*;
	logic [7:0] last;
	// Floating pins wander so no stale level reads back
	always_ff @(posedge clk) begin
		last <= pin;
	end
	assign pin = (drive.oe & drive.dout) | (~drive.oe & ext_en & ext) | (~drive.oe & ~ext_en & (pull_en | ~last));
endmodule
`default_nettype wire

// ---- tb/mpio_checker.sv ----
// Port-level assertions for the multi-port pin I/O block.
// Assumes it is bound onto mpio_top, one clock domain.
`default_nettype none
module mpio_checker (
	// Clock, reset and bus
	input wire logic clk,
	input wire logic rst_b,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	// Port drives and controls
	input wire mpio_pkg::mpio_pin8_t irq_port_drive,
	input wire logic [7:0] irq_port_pullup,
	input wire mpio_pkg::mpio_pin8_t shared_port_drive,
	input wire mpio_pkg::mpio_periph_t shared_periph,
	input wire logic i2c_enable,
	input wire logic serial_cke,
	input wire logic shared_smbus_levels,
	input wire mpio_pkg::mpio_pin8_t parallel_port_drive,
	input wire logic parallel_slave_select,
	input wire mpio_pkg::mpio_psp_ctl_t psp_ctl,
	input wire logic [7:0] option_value,
	input wire logic low_voltage_programming
);
	timeunit 1ns;
	timeprecision 1ps;
	import mpio_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_wait_one; (avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
	a_wait_one: assert property (p_wait_one) else $error("bus answer not after one wait");
	property p_override; ((shared_port_drive.oe ^ shared_periph.oe) & shared_periph.sel) == 8'h00
		&& ((shared_port_drive.dout ^ shared_periph.dout) & shared_periph.sel) == 8'h00; endproperty
	a_override: assert property (p_override) else $error("selected peripheral not driving pin");
	property p_sel_only; $changed(shared_periph.oe) && $stable(shared_periph.sel) && !$past(avs_write)
		|-> ((shared_port_drive.oe ^ $past(shared_port_drive.oe)) & ~shared_periph.sel) == 8'h00; endproperty
	a_sel_only: assert property (p_sel_only) else $error("unselected peripheral enable leaked");
	property p_pull_off; option_value[7] |-> irq_port_pullup == 8'h00; endproperty
	a_pull_off: assert property (p_pull_off) else $error("pull-ups on while disabled");
	property p_pull_on; !option_value[7] |-> ((irq_port_pullup ^ ~irq_port_drive.oe) & 8'hF7) == 8'h00; endproperty
	a_pull_on: assert property (p_pull_on) else $error("pull-up not following input pins");
	property p_prog_pin; low_voltage_programming |-> !irq_port_drive.oe[3]; endproperty
	a_prog_pin: assert property (p_prog_pin) else $error("bit 3 driven in programming mode");
	property p_slave_oe; parallel_slave_select |-> parallel_port_drive.oe == 8'h00; endproperty
	a_slave_oe: assert property (p_slave_oe) else $error("parallel port driven in slave mode");
	property p_strobe_idle; !parallel_slave_select |-> psp_ctl == 3'h7; endproperty
	a_strobe_idle: assert property (p_strobe_idle) else $error("strobes active outside slave mode");
	property p_levels; shared_smbus_levels == (i2c_enable & serial_cke); endproperty
	a_levels: assert property (p_levels) else $error("input level select wrong");
	property p_dir_rst; $rose(rst_b) |-> irq_port_drive.oe == 8'h00 && parallel_port_drive.oe == 8'h00; endproperty
	a_dir_rst: assert property (p_dir_rst) else $error("pins driven after reset");
endmodule
bind mpio_top mpio_checker i_chk (.clk, .rst_b, .avs_read, .avs_write, .avs_waitrequest, .irq_port_drive,
	.irq_port_pullup, .shared_port_drive, .shared_periph, .i2c_enable, .serial_cke, .shared_smbus_levels,
	.parallel_port_drive, .parallel_slave_select, .psp_ctl, .option_value, .low_voltage_programming);
`default_nettype wire

// ---- tb/multi_port_pin_io_bench.sv ----
// Self-checking bench for the multi-port pin I/O block.
// Assumes the pin model on the far side and the checker bound to the top.
`default_nettype none
module multi_port_pin_io_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import mpio_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [MPIO_ADDR_W-1:0] avs_address = '0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [MPIO_DATA_W-1:0] avs_writedata = '0;
	logic [MPIO_DATA_W-1:0] avs_readdata;
	logic avs_waitrequest, parallel_slave_select, change_irq_flag, shared_smbus_levels;
	logic [7:0] irq_port_in, shared_port_in, parallel_port_in, irq_port_pullup, irq_en = 8'hFF;
	logic [7:0] ext [3] = '{8'h08, 8'h00, 8'h00};
	mpio_pin8_t irq_port_drive, shared_port_drive, parallel_port_drive;
	mpio_periph_t shared_periph = '0;
	mpio_psp_ctl_t psp_ctl;
	logic [3:0] avs_byteenable = 4'hF;
	logic [7:0] parallel_port_pins, option_value, s8;
	logic port_ttl_buffers, external_irq_pin, external_irq_rising, low_voltage_programming;
	logic lowvolt_prog_pin, prog_clock_pin, prog_data_pin;
	mpio_pin3_t control_port_drive;
	mpio_serial_in_t shared_periph_in;
	int rises = 0, rise_base = 0;
	logic i2c_enable = 1'b0, serial_cke = 1'b0, change_flag_clear = 1'b0;
	logic input_buffer_full = 1'b0, output_buffer_full = 1'b0;
	logic [2:0] control_port_in = 3'h0, control_analog = 3'h7;
	logic [7:0] m [256];
	logic [7:0] r8;
	logic [31:0] rnd = 32'h7A7A;
	int failures = 0, total_checks = 0;
	always #20 clk = ~clk;
	// Count one-cycle edge pulses of the external interrupt
	always @(posedge clk) begin
		if (external_irq_rising === 1'b1)
			rises <= rises + 1;
	end
	mpio_top i_dut (.clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
		.avs_readdata, .avs_waitrequest, .irq_port_in, .irq_port_drive, .irq_port_pullup, .shared_port_in,
		.shared_port_drive, .shared_periph, .shared_periph_in, .i2c_enable, .serial_cke, .shared_smbus_levels,
		.parallel_port_in, .parallel_port_drive, .parallel_port_pins, .parallel_slave_select,
		.port_ttl_buffers, .control_port_in, .control_port_drive, .control_analog, .psp_ctl,
		.input_buffer_full, .output_buffer_full, .option_value, .external_irq_pin, .external_irq_rising,
		.change_irq_flag, .change_flag_clear, .low_voltage_programming, .lowvolt_prog_pin,
		.prog_clock_pin, .prog_data_pin);
	mpio_pins i_irq (.clk, .drive(irq_port_drive), .pull_en(irq_port_pullup), .ext(ext[0]), .ext_en(irq_en),
		.pin(irq_port_in));
	mpio_pins i_shr (.clk, .drive(shared_port_drive), .pull_en(8'h00), .ext(ext[1]), .ext_en(8'hFF),
		.pin(shared_port_in));
	mpio_pins i_par (.clk, .drive(parallel_port_drive), .pull_en(8'h00), .ext(ext[2]), .ext_en(8'hFF),
		.pin(parallel_port_in));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] pinv(input logic [7:0] dir, input logic [7:0] lat, input logic [7:0] e);
		return (~dir & lat) | (dir & e);
	endfunction
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Hold the request until waitrequest is seen low
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
		avs_address <= {idx, 2'h0};
		avs_writedata <= {24'h000000, wd};
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) @(posedge clk);
		rd = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		m[idx] = d;
		bus(1'b1, idx, d, r8);
	endtask
	task automatic rdc(input string what, input logic [7:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h00, r8);
		chk(what, exp, r8);
	endtask
	task automatic close_out;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (4000) @(posedge clk);
		failures++;
		close_out();
	end
	initial begin
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		for (int p = 0; p < 3; p++) rdc("dir", MPIO_IDX_IRQ_DIR + 8'(p), 8'hFF);
		rdc("option", MPIO_IDX_OPTION, 8'hFF);
		rdc("ctl dir", MPIO_IDX_CTL_DIR, 8'h07);
		rdc("ctl data", MPIO_IDX_CTL_DATA, 8'h00);
		rdc("unmapped", 8'h3F, 8'h00);
		wr(MPIO_IDX_IRQ_DIR, 8'h00);
		chk("irq oe", 8'hF7, irq_port_drive.oe);
		chk("lvp on", 8'h03, {6'h00, low_voltage_programming, lowvolt_prog_pin});
		rdc("irq lvp", MPIO_IDX_IRQ_DATA, 8'h00);
		wr(MPIO_IDX_STATUS, 8'h00);
		chk("irq oe", 8'hFF, irq_port_drive.oe);
		for (int i = 0; i < 6; i++) begin
			for (int p = 0; p < 3; p++) begin
				rnd = lfsr(rnd);
				wr(MPIO_IDX_IRQ_DATA + 8'(p), rnd[7:0]);
				wr(MPIO_IDX_IRQ_DIR + 8'(p), rnd[15:8]);
				ext[p] <= rnd[23:16];
			end
			{i2c_enable, serial_cke} <= rnd[25:24];
			repeat (3) @(posedge clk);
			chk("smbus", {7'h00, rnd[25] & rnd[24]}, {7'h00, shared_smbus_levels});
			chk("par pins", pinv(m[136], m[8], ext[2]), parallel_port_pins);
			s8 = pinv(m[135], m[7], ext[1]);
			chk("periph in", {s8[0], s8[1], s8[1], s8[2], s8[3], s8[4], s8[6], s8[7]}, shared_periph_in);
			s8 = pinv(m[134], m[6], ext[0]);
			chk("irq alt", {5'h00, s8[7], s8[6], s8[0]}, {5'h00, prog_data_pin, prog_clock_pin, external_irq_pin});
			chk("lvp off", 8'h00, {6'h00, low_voltage_programming, lowvolt_prog_pin});
			for (int p = 0; p < 3; p++) rdc("pins", MPIO_IDX_IRQ_DATA + 8'(p), pinv(m[134 + p], m[6 + p], ext[p]));
		end
		rnd = lfsr(rnd);
		shared_periph <= rnd[23:0];
		@(posedge clk);
		chk("shared oe", (shared_periph.sel & shared_periph.oe) | (~shared_periph.sel & ~m[135]), shared_port_drive.oe);
		chk("shared out", (shared_periph.sel & shared_periph.dout) | (~shared_periph.sel & m[7]), shared_port_drive.dout);
		rdc("shared dir", MPIO_IDX_SHARED_DIR, (m[135] & ~rnd[23:16]) | (~rnd[15:8] & rnd[23:16]));
		shared_periph.oe <= ~rnd[15:8];
		@(posedge clk);
		chk("oe only", (rnd[23:16] & ~rnd[15:8]) | (~rnd[23:16] & ~m[135]), shared_port_drive.oe);
		shared_periph <= '0;
		wr(MPIO_IDX_OPTION, 8'h7F);
		chk("pullup", m[134] & 8'hFF, irq_port_pullup);
		chk("option out", 8'h7F, option_value);
		avs_byteenable <= 4'hE;
		wr(MPIO_IDX_OPTION, 8'h00);
		avs_byteenable <= 4'hF;
		rdc("option be", MPIO_IDX_OPTION, 8'h7F);
		wr(MPIO_IDX_IRQ_DIR, 8'hFF);
		irq_en <= 8'h00;
		repeat (3) @(posedge clk);
		rdc("pulled", MPIO_IDX_IRQ_DATA, 8'hFF);
		irq_en <= 8'hFF;
		ext[0] <= 8'h00;
		repeat (3) @(posedge clk);
		rdc("irq pins", MPIO_IDX_IRQ_DATA, 8'h00);
		wr(MPIO_IDX_STATUS, 8'h01);
		rdc("status", MPIO_IDX_STATUS, 8'h00);
		rise_base = rises;
		ext[0] <= 8'h01;
		repeat (3) @(posedge clk);
		chk("flag", 8'h00, {7'h00, change_irq_flag});
		ext[0] <= 8'h21;
		repeat (4) @(posedge clk);
		chk("flag", 8'h01, {7'h00, change_irq_flag});
		chk("rises", 8'h01, 8'(rises - rise_base));
		rdc("irq pins", MPIO_IDX_IRQ_DATA, 8'h21);
		change_flag_clear <= 1'b1;
		@(posedge clk);
		change_flag_clear <= 1'b0;
		@(posedge clk);
		chk("flag", 8'h00, {7'h00, change_irq_flag});
		rnd = lfsr(rnd);
		control_port_in <= rnd[2:0];
		control_analog <= rnd[5:3];
		{input_buffer_full, output_buffer_full} <= rnd[7:6];
		repeat (3) @(posedge clk);
		rdc("ctl data", MPIO_IDX_CTL_DATA, {5'h00, rnd[2:0] & ~rnd[5:3]});
		control_analog <= 3'h0;
		wr(MPIO_IDX_CTL_DIR, 8'h17);
		rdc("ctl dir", MPIO_IDX_CTL_DIR, {rnd[7:6], 6'h17});
		chk("slave", 8'h03, {6'h00, parallel_slave_select, port_ttl_buffers});
		chk("strobes", {5'h00, rnd[0], rnd[1], rnd[2]}, {5'h00, psp_ctl});
		chk("par oe", 8'h00, parallel_port_drive.oe);
		wr(MPIO_IDX_CTL_DIR, 8'h07);
		chk("slave", 8'h00, {6'h00, parallel_slave_select, port_ttl_buffers});
		control_analog <= 3'h7;
		wr(MPIO_IDX_CTL_DATA, 8'h05);
		wr(MPIO_IDX_CTL_DIR, 8'h02);
		chk("ctl drive", 8'h2D, {2'h0, control_port_drive});
		rdc("ctl analog", MPIO_IDX_CTL_DATA, 8'h00);
		close_out();
	end
endmodule
`default_nettype wire
